// >>> rtl/lei_injector.sv
// register bank, bit-error injector and control-channel lock status
//
// Overview of operation
// - the rate field sets the mean error spacing to 2560, 40960, 655360 or 10485760 bits.
// - the kind field makes each error flip one bit or corrupt two, three or four symbols, save the last error of a limited run, which flips one bit.
// - the quantity field allows unlimited errors or a run of 16, 128 or 1024 errors.
// - periodic select 1 spaces errors exactly by the rate, 0 spaces them randomly on average.
// - errors are produced only while the enable bit is 1, and writing 0 stops them.
// - writing 1 to power-down bit 7 resets the device and the bit clears itself when done.
// - a read-only bit shows 1 while the control channel holds its word boundary.
// - a read-only bit at position 0 shows 1 while the far-side control channel is locked.
`timescale 1ns/1ps
module lei_injector
  import lei_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              wb_lock_pin,
  input  wire logic              far_lock_pin,
  input  wire logic              enc_bit,
  input  wire logic              enc_valid,
  output logic                   line_bit,
  output logic                   line_valid,
  output logic                   device_reset,
  output logic                   irq
);

  lei_state_type s;
  lei_state_type next_s;

  logic [7:0]      reg_idx;
  logic            idx_ok;
  logic            wr_take;
  logic            setup;
  logic [7:0]      rd_val;
  logic [1:0]      rate_code;
  logic [1:0]      kind_code;
  logic [1:0]      qty_code;
  logic            inj_en;
  logic [23:0]     period;
  logic [31:0]     thresh;
  logic [10:0]     qty_limit;
  logic [5:0]      burst_len;
  logic            hit;
  logic            fire;
  logic            flip;
  logic            in_burst;
  logic            idx_mapped;
  logic [EV_N-1:0] events;
  logic [31:0]     lfsr_step;
  logic [31:0]     lfsr_chain [0:32];

  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign prdata       = s.prdata;
  assign line_bit     = s.tx_bit;
  assign line_valid   = s.tx_valid;
  assign device_reset = s.device_reset;
  assign irq          = s.irq;

  // random mode moves the generator a whole word per valid bit: single
  // steps only shift the word, so hits would come in bunches
  assign lfsr_chain[0] = s.lfsr;
  for (genvar g = 0; g < 32; g++) begin : g_lfsr
    assign lfsr_chain[g+1] = lfsr_chain[g][0] ? ((lfsr_chain[g] >> 1) ^ LFSR_TAPS)
                                              : (lfsr_chain[g] >> 1);
  end

  always_comb begin
    reg_idx   = paddr[9:2];
    idx_ok    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    setup     = psel && !penable && !s.pready;
    wr_take   = psel && penable && s.pready && pwrite && !s.pslverr;
    rate_code = s.inj_cfg[CFG_RATE_LSB +: 2];
    kind_code = s.inj_cfg[CFG_KIND_LSB +: 2];
    qty_code  = s.inj_cfg[CFG_QTY_LSB +: 2];
    // injector held off during a software reset
    inj_en    = s.inj_cfg[CFG_EN_BIT] && (s.srst_state == SRST_IDLE);
    unique case (rate_code)
      2'b00: begin
        period = PERIOD_0;
        thresh = THRESH_0;
      end
      2'b01: begin
        period = PERIOD_1;
        thresh = THRESH_1;
      end
      2'b10: begin
        period = PERIOD_2;
        thresh = THRESH_2;
      end
      2'b11: begin
        period = PERIOD_3;
        thresh = THRESH_3;
      end
    endcase
    // a zero limit lets the run go on for ever
    unique case (qty_code)
      2'b00: begin
        qty_limit = '0;
      end
      2'b01: begin
        qty_limit = QTY_1;
      end
      2'b10: begin
        qty_limit = QTY_2;
      end
      2'b11: begin
        qty_limit = QTY_3;
      end
    endcase
    // symbol errors span whole 10-bit codes
    unique case (kind_code)
      2'b00: begin
        burst_len = 6'h01;
      end
      2'b01: begin
        burst_len = 6'(2 * SYMBOL_BITS);
      end
      2'b10: begin
        burst_len = 6'(3 * SYMBOL_BITS);
      end
      2'b11: begin
        burst_len = 6'(4 * SYMBOL_BITS);
      end
    endcase
    lfsr_step = lfsr_chain[32];
    in_burst  = (s.burst_left != '0);
    // periodic mode hits on the counter wrap, random mode on a threshold
    if (s.inj_cfg[CFG_PER_BIT]) begin
      hit = (s.bit_count == period - 24'h00_0001);
    end else begin
      hit = (s.lfsr < thresh);
    end
    // a hit inside a running burst is dropped so bursts never merge
    fire = inj_en && enc_valid && hit && !s.run_done && !in_burst;
    // symbol bursts invert the first bit and every second one after it; the last burst of a limited run stops after its first bit
    flip = inj_en && enc_valid && !s.run_done &&
           (fire || (in_burst && !s.burst_left[0]));
  end

  // one decode serves read data and the refusal of unmapped indices
  always_comb begin
    idx_mapped = 1'b1;
    unique case (reg_idx)
      IDX_INJ_CFG: begin
        rd_val = s.inj_cfg;
      end
      IDX_RSVD_12: begin
        rd_val = s.rsvd_12;
      end
      IDX_PWR_DOWN: begin
        rd_val = {s.software_reset_request, s.pd_low};
      end
      IDX_LOCK_STAT: begin
        rd_val = {6'h00, s.control_word_boundary_locked,
                  s.far_side_control_locked};
      end
      IDX_IRQ_STAT: begin
        rd_val = {5'h00, s.irq_status};
      end
      IDX_IRQ_MASK: begin
        rd_val = {5'h00, s.irq_mask};
      end
      default: begin
        rd_val     = 8'h00;
        idx_mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    events = '0;

    // bus answer one cycle after setup
    next_s.pready = setup;
    if (setup) begin
      next_s.pslverr = !idx_ok || !idx_mapped;
      // a refused access answers with zero data
      next_s.prdata  = (idx_ok && idx_mapped) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end else begin
      // answer stands for one cycle only
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
    end

    // pin synchronisers, three stages
    next_s.wb_sync  = {s.wb_sync[1:0], wb_lock_pin};
    next_s.far_sync = {s.far_sync[1:0], far_lock_pin};
    if (s.wb_sync[1] == s.wb_sync[2]) begin
      next_s.control_word_boundary_locked = s.wb_sync[2];
      events[EV_WB_CHANGE] = (s.wb_sync[2] != s.control_word_boundary_locked);
    end
    if (s.far_sync[1] == s.far_sync[2]) begin
      next_s.far_side_control_locked = s.far_sync[2];
      events[EV_FAR_CHANGE] = (s.far_sync[2] != s.far_side_control_locked);
    end

    // injector datapath on the encoded stream
    next_s.tx_valid = enc_valid;
    next_s.tx_bit   = enc_bit ^ flip;
    if (enc_valid) begin
      next_s.lfsr = lfsr_step;
      if (inj_en) begin
        next_s.bit_count = hit ? 24'h00_0000 : s.bit_count + 24'h00_0001;
      end
      if (fire) begin
        next_s.burst_left = burst_len - 6'h01;
        next_s.err_count  = s.err_count + 11'h001;
        if ((qty_limit != '0) && (s.err_count + 11'h001 == qty_limit)) begin
          next_s.run_done = 1'b1;
          events[EV_RUN_DONE] = 1'b1;
        end
      end else if (in_burst) begin
        next_s.burst_left = s.burst_left - 6'h01;
      end
    end
    if (!inj_en) begin
      // disabled: stop at once and arm a fresh run
      next_s.bit_count  = '0;
      next_s.burst_left = '0;
      next_s.err_count  = '0;
      next_s.run_done   = 1'b0;
    end

    // register writes; reserved fields are stored as written
    if (wr_take) begin
      unique case (reg_idx)
        IDX_INJ_CFG: begin
          next_s.inj_cfg = pwdata[7:0];
        end
        IDX_RSVD_12: begin
          next_s.rsvd_12 = pwdata[7:0];
        end
        IDX_PWR_DOWN: begin
          next_s.pd_low = pwdata[6:0];
          if (pwdata[PD_SRST_BIT]) begin
            next_s.software_reset_request = 1'b1;
          end
        end
        IDX_IRQ_MASK: begin
          next_s.irq_mask = pwdata[EV_N-1:0];
        end
        IDX_IRQ_STAT: begin
          next_s.irq_status = s.irq_status & ~pwdata[EV_N-1:0];
        end
        default:      next_s.irq_mask = s.irq_mask;
      endcase
    end
    // set wins over a same-cycle clear
    next_s.irq_status = next_s.irq_status | events;

    // software reset sequence
    unique case (s.srst_state)
      SRST_IDLE: begin
        if (s.software_reset_request) begin
          next_s.srst_state   = SRST_BUSY;
          next_s.srst_count   = SRST_CYCLES;
          next_s.device_reset = 1'b1;
        end
      end
      SRST_BUSY: begin
        next_s.srst_count = s.srst_count - 5'h01;
        if (s.srst_count == 5'h01) begin
          // reset done: defaults back, request bit clears itself
          next_s.srst_state             = SRST_IDLE;
          next_s.device_reset           = 1'b0;
          next_s.software_reset_request = 1'b0;
          next_s.inj_cfg                = RST_INJ_CFG;
          next_s.rsvd_12                = RST_RSVD_12;
          next_s.pd_low                 = RST_PD_LOW;
          next_s.irq_mask               = '0;
          next_s.irq_status             = '0;
        end
      end
    endcase

    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.inj_cfg    <= RST_INJ_CFG;
      s.rsvd_12    <= RST_RSVD_12;
      s.pd_low     <= RST_PD_LOW;
      s.srst_state <= SRST_IDLE;
      s.lfsr       <= LFSR_SEED;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

endmodule : lei_injector

// >>> rtl/lei_pkg.sv
// constants, types and state layout of the link error injector and status block
package lei_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_INJ_CFG   = 8'h11;
  localparam logic [7:0]  IDX_RSVD_12   = 8'h12;
  localparam logic [7:0]  IDX_PWR_DOWN  = 8'h13;
  localparam logic [7:0]  IDX_LOCK_STAT = 8'h14;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h20;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h21;
  localparam int          ADDR_W        = 12;
  // reset values
  localparam logic [7:0]  RST_INJ_CFG   = 8'h00;
  localparam logic [7:0]  RST_RSVD_12   = 8'h40;
  localparam logic [6:0]  RST_PD_LOW    = 7'h02;
  // field positions inside the injector configuration, power-down and lock status registers
  localparam int          CFG_RATE_LSB  = 6;
  localparam int          CFG_KIND_LSB  = 4;
  localparam int          CFG_QTY_LSB   = 2;
  localparam int          CFG_PER_BIT   = 1;
  localparam int          CFG_EN_BIT    = 0;
  localparam int          PD_SRST_BIT   = 7;
  localparam int          LOCK_WB_BIT   = 1;
  localparam int          LOCK_FAR_BIT  = 0;
  // interrupt status bit positions
  localparam int          EV_RUN_DONE   = 0;
  localparam int          EV_WB_CHANGE  = 1;
  localparam int          EV_FAR_CHANGE = 2;
  localparam int          EV_N          = 3;
  // spacing of errors in bits, per rate code
  localparam logic [23:0] PERIOD_0      = 24'h00_0A00;
  localparam logic [23:0] PERIOD_1      = 24'h00_A000;
  localparam logic [23:0] PERIOD_2      = 24'h0A_0000;
  localparam logic [23:0] PERIOD_3      = 24'hA0_0000;
  // per-bit hit thresholds on a 32-bit random word: 2^32 / spacing
  localparam logic [31:0] THRESH_0      = 32'h0019_999A;
  localparam logic [31:0] THRESH_1      = 32'h0001_999A;
  localparam logic [31:0] THRESH_2      = 32'h0000_199A;
  localparam logic [31:0] THRESH_3      = 32'h0000_019A;
  localparam logic [31:0] LFSR_SEED     = 32'hACE1_0001;
  localparam logic [31:0] LFSR_TAPS     = 32'h8020_0003;
  // error counts per quantity code; zero means unlimited
  localparam logic [10:0] QTY_1         = 11'h010;
  localparam logic [10:0] QTY_2         = 11'h080;
  localparam logic [10:0] QTY_3         = 11'h400;
  localparam logic [5:0]  SYMBOL_BITS   = 6'h0A;
  localparam logic [4:0]  SRST_CYCLES   = 5'h10;

  typedef enum logic [0:0] {
    SRST_IDLE = 1'b0,
    SRST_BUSY = 1'b1
  } lei_srst_state_type;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [7:0]            inj_cfg;
    logic [7:0]            rsvd_12;
    logic [6:0]            pd_low;
    logic                  software_reset_request;
    lei_srst_state_type    srst_state;
    logic [4:0]            srst_count;
    logic                  device_reset;
    logic [2:0]            wb_sync;
    logic [2:0]            far_sync;
    logic                  control_word_boundary_locked;
    logic                  far_side_control_locked;
    logic [EV_N-1:0]       irq_status;
    logic [EV_N-1:0]       irq_mask;
    logic                  irq;
    logic [23:0]           bit_count;
    logic [31:0]           lfsr;
    logic [5:0]            burst_left;
    logic [10:0]           err_count;
    logic                  run_done;
    logic                  tx_bit;
    logic                  tx_valid;
  } lei_state_type;
endpackage : lei_pkg

// >>> verif/lei_injector_chk.sv
// concurrent checks on the injector's bus, line and reset ports
`timescale 1ns/1ps
module lei_injector_chk
  import lei_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire logic              enc_valid,
  input wire logic              line_valid,
  input wire logic              device_reset
);
  logic [7:0] hi_cnt;
  // length of the software reset pulse, checked at its fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= device_reset ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  bad_align_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  srst_start_a: assert property (
    psel && penable && pready && pwrite && paddr == {2'b00, IDX_PWR_DOWN, 2'b00} &&
    pwdata[PD_SRST_BIT] |-> ##2 device_reset)
    else $error("software reset did not start");
  srst_len_a: assert property ($fell(device_reset) |-> hi_cnt == 8'h10)
    else $error("software reset length wrong");
  valid_delay_a: assert property (
    @(posedge pclk) disable iff (!presetn || device_reset) 1'b1 |=> line_valid == $past(enc_valid))
    else $error("line valid not one cycle behind");
  cover property (pslverr);
  cover property ($rose(device_reset));
  cover property (psel && penable && pready && !pwrite);
endmodule : lei_injector_chk

bind lei_injector lei_injector_chk i_lei_injector_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .enc_valid(enc_valid), .line_valid(line_valid), .device_reset(device_reset)
);

// >>> verif/lei_far_model.sv
// far-side receiver model: feeds encoded bits and counts line errors
`timescale 1ns/1ps
module lei_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic line_bit,
  input  wire logic line_valid,
  output logic      enc_bit,
  output logic      enc_valid,
  output int        flips,
  output int        gap
);
  logic sent_q;
  int   vcnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {enc_bit, enc_valid, sent_q} <= 3'b000;
      flips <= 0;
      gap <= 0;
      vcnt <= 0;
    end else begin
      // stalls one bit in eight so spacing counts only valid bits
      enc_bit <= 1'($urandom_range(1));
      enc_valid <= ($urandom_range(7) != 0);
      sent_q <= enc_bit;
      if (line_valid && line_bit != sent_q) begin
        flips <= flips + 1;
        gap <= vcnt + 1;
        vcnt <= 0;
      end else if (line_valid) begin
        vcnt <= vcnt + 1;
      end
    end
  end
endmodule : lei_far_model

// >>> verif/link_error_injector_and_status_bench.sv
// self-checking bench of the link error injector and status block
`timescale 1ns/1ps
module link_error_injector_and_status_bench;
  import lei_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, wb_pin, far_pin;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, r;
  logic              pready, pslverr, enc_bit, enc_valid, line_bit, line_valid, dev_rst, irq;
  logic [9:0]        e_mon;
  logic [9:0]        expq[$];
  logic [7:0]        v;
  int                flips, gap, fails, n_tests, f0, i;

  lei_injector i_lei_injector (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .wb_lock_pin(wb_pin), .far_lock_pin(far_pin),
    .enc_bit(enc_bit), .enc_valid(enc_valid), .line_bit(line_bit), .line_valid(line_valid),
    .device_reset(dev_rst), .irq(irq));
  lei_far_model i_lei_far_model (.pclk(pclk), .presetn(presetn), .line_bit(line_bit),
    .line_valid(line_valid), .enc_bit(enc_bit), .enc_valid(enc_valid), .flips(flips),
    .gap(gap));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // e = {write, error expected, read byte}
  task automatic xfer(logic wr, logic [ADDR_W-1:0] a, logic [7:0] d, logic [9:0] e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    expq.push_back(e);
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    if (!pready) begin
      fails++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rd(logic [7:0] idx, logic [7:0] d);
    xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00, {2'b00, d});
  endtask : rd

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    xfer(1'b1, {2'b00, idx, 2'b00}, d, 10'h200);
  endtask : wr

  // answers are compared where they appear, against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e_mon = expq.pop_front();
      chk("pslverr", {31'h0, e_mon[8]}, {31'h0, pslverr});
      if (!e_mon[9]) chk("prdata", {24'h00_0000, e_mon[7:0]}, prdata);
    end
  end

  initial begin
    r = $urandom(48);
    {psel, penable, pwrite, wb_pin, far_pin, presetn} = 6'h00;
    paddr = '0;
    pwdata = '0;
    cyc(20);
    presetn <= 1'b1;
    cyc(2);
    rd(IDX_INJ_CFG, RST_INJ_CFG);
    rd(IDX_RSVD_12, RST_RSVD_12);
    rd(IDX_PWR_DOWN, {1'b0, RST_PD_LOW});
    rd(IDX_LOCK_STAT, 8'h00);
    xfer(1'b1, {2'b00, 8'h3F, 2'b00}, 8'hFF, 10'h300);
    xfer(1'b0, {2'b00, IDX_RSVD_12, 2'b10}, 8'h00, 10'h100);
    v = 8'($urandom) & 8'hFE;
    wr(IDX_INJ_CFG, v);
    rd(IDX_INJ_CFG, v);
    wb_pin <= 1'b1;
    cyc(8);
    rd(IDX_LOCK_STAT, 8'h02);
    far_pin <= 1'b1;
    cyc(8);
    rd(IDX_LOCK_STAT, 8'h03);
    rd(IDX_IRQ_STAT, 8'h06);
    chk("irq", 0, {31'h0, irq});
    wr(IDX_IRQ_MASK, 8'h07);
    cyc(2);
    chk("irq", 1, {31'h0, irq});
    wr(IDX_IRQ_STAT, 8'h06);
    cyc(2);
    chk("irq", 0, {31'h0, irq});
    // periodic single-bit run of 16 errors
    f0 = flips;
    wr(IDX_INJ_CFG, 8'h07);
    for (i = 0; i < 60000 && !irq; i++) @(posedge pclk);
    if (!irq) begin
      fails++;
      close_out();
    end
    cyc(5);
    chk("run errors", 16, flips - f0);
    chk("spacing", 2560, gap);
    cyc(3000);
    chk("after run", f0 + 16, flips);
    rd(IDX_IRQ_STAT, 8'h01);
    wr(IDX_IRQ_STAT, 8'h01);
    wr(IDX_INJ_CFG, 8'h06);
    for (int k = 1; k < 4; k++) begin
      f0 = flips;
      wr(IDX_INJ_CFG, {2'b00, 2'(k), 4'b0011});
      cyc(3300);
      wr(IDX_INJ_CFG, 8'h00);
      chk("burst flips", f0 + 5 * (k + 1), flips);
      cyc(3000);
      chk("stopped", f0 + 5 * (k + 1), flips);
    end
    f0 = flips;
    wr(IDX_INJ_CFG, 8'h01);
    cyc(20000);
    wr(IDX_INJ_CFG, 8'h00);
    chk("random count", 1, {31'h0, flips - f0 > 1 && flips - f0 < 20});
    wr(IDX_INJ_CFG, 8'h5C);
    wr(IDX_PWR_DOWN, 8'h82);
    rd(IDX_PWR_DOWN, 8'h82);
    cyc(25);
    rd(IDX_PWR_DOWN, 8'h02);
    rd(IDX_INJ_CFG, RST_INJ_CFG);
    close_out();
  end
endmodule : link_error_injector_and_status_bench
